//--- rtl/disk_ctrl_pkg.sv
package disk_ctrl_pkg;
	// register byte offsets on the wishbone window
	localparam logic [7:0] OFF_COMMAND = 8'h00;
	localparam logic [7:0] OFF_PARAM0 = 8'h04;
	localparam logic [7:0] OFF_PARAM1 = 8'h08;
	localparam logic [7:0] OFF_SELECT = 8'h0c;
	localparam logic [7:0] OFF_TARGET = 8'h10;
	localparam logic [7:0] OFF_RESULT = 8'h14;
	localparam logic [7:0] OFF_XFER = 8'h18;
	localparam logic [7:0] OFF_FIELD = 8'h1c;
	localparam logic [7:0] OFF_DRIVE = 8'h20;
	localparam logic [7:0] OFF_STATE = 8'h24;

	// command bytes understood by the interpreter
	localparam logic [7:0] CMD_SPECIFY = 8'h03;
	localparam logic [7:0] CMD_SENSE_DRIVE = 8'h04;
	localparam logic [7:0] CMD_WRITE = 8'h05;
	localparam logic [7:0] CMD_READ = 8'h06;
	localparam logic [7:0] CMD_RECAL = 8'h07;
	localparam logic [7:0] CMD_SENSE_INT = 8'h08;
	localparam logic [7:0] CMD_SEEK = 8'h0f;

	// termination codes in result bits 7:6
	localparam logic [1:0] TERM_NORMAL = 2'h0;
	localparam logic [1:0] TERM_ABNORMAL = 2'h1;
	localparam logic [1:0] TERM_INVALID = 2'h2;
	localparam logic [1:0] TERM_READY = 2'h3;

	// field positions
	localparam int BIT_WRITE_BLOCKED = 1;
	localparam int BIT_MARK_MISSING = 0;
	localparam int BIT_DATA_MARK_MISSING = 0;
	localparam int BIT_CYL_MISMATCH = 4;
	localparam int BIT_BAD_TRACK = 1;
	localparam int SEL_HALF_RATE = 3;
	localparam int SEL_SIDE = 2;

	// bits that exist; the others always read zero
	localparam logic [7:0] XFER_USED_MASK = 8'hb7;
	localparam logic [7:0] FIELD_USED_MASK = 8'h7f;
	localparam logic [7:0] FIELD_ERROR_MASK = 8'h33;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// timing
	localparam int MS_NS = 1000000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_CYCLES_NOM = MS_NS / CLK_PERIOD_NS;
	localparam logic [4:0] STEP_SPAN_MS = 5'h10;
	localparam logic [8:0] SETTLE_UNIT_MS = 9'h002;
	localparam logic [6:0] RECAL_STEP_LIMIT = 7'h4d;

	typedef enum {RW_IDLE, RW_SETTLE, RW_EXEC} rw_state_type;
	typedef enum {SK_IDLE, SK_CHECK, SK_WAIT} seek_state_type;
endpackage : disk_ctrl_pkg

//--- rtl/timer_if.sv
`timescale 1ns/1ps
// start pulse with a length in milliseconds, done pulse when it runs out
interface timer_if;
	logic start;
	logic [8:0] ms_count;
	logic done;
	logic busy;
	modport ctl (output start, output ms_count, input done, input busy);
	modport tmr (input start, input ms_count, output done, output busy);
endinterface : timer_if

//--- rtl/interval_timer.sv
`timescale 1ns/1ps
module interval_timer #(
	parameter int MS_CYCLES = disk_ctrl_pkg::MS_CYCLES_NOM
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic half_rate_i,
	timer_if.tmr tmr
);
	logic [31:0] pre_r;
	logic [31:0] limit;
	logic [8:0] left_r;
	logic run_r;

	generate
		if (MS_CYCLES < 1) begin : g_bad_rate
			$error("MS_CYCLES must be at least one");
		end
	endgenerate

	// slow clock doubles every interval, as the drive expects
	assign limit = half_rate_i ? 32'(2 * MS_CYCLES - 1) : 32'(MS_CYCLES - 1); // RL8

	// millisecond prescaler and down counter; a restart simply reloads
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_r <= 1'b0;
			left_r <= '0;
			pre_r <= '0;
		end else if (tmr.start) begin
			run_r <= 1'b1;
			left_r <= tmr.ms_count;
			pre_r <= '0;
		end else if (run_r) begin
			if (left_r == 9'h000) begin
				run_r <= 1'b0;
			end else if (pre_r == limit) begin
				pre_r <= '0;
				left_r <= left_r - 9'h001; // RL8
			end else begin
				pre_r <= pre_r + 32'h0000_0001;
			end
		end
	end

	assign tmr.done = run_r && (left_r == 9'h000);
	assign tmr.busy = run_r;
endmodule : interval_timer

//--- rtl/disk_ctrl_status_interrupt.sv
`timescale 1ns/1ps
// Contract
// RL1 - interrupt on ready change, positioning end, and non-DMA byte requests
// RL2 - sense-interrupt clears interrupt and reports cause in result bits 7:5
// RL3 - cause codes: ready change 011, normal end 100, abnormal end 110 (bit5..7)
// RL4 - host must sense interrupt after each seek or recalibrate
// RL5 - head unload delay is code times 16 ms after a transfer ends
// RL6 - step interval is 16 minus code milliseconds, one to sixteen
// RL7 - head settle delay after head load is 2 ms plus 2 ms per code
// RL8 - all delays count the clock and double in slow-clock mode
// RL9 - transfer mode bit one selects processor transfers, zero selects DMA
// RL10 - undefined command does nothing and reports termination code 10
// RL11 - any command other than sense-interrupt after positioning end is invalid
// RL12 - termination code 00 normal, 01 abnormal, 10 invalid, 11 ready lost
// RL13 - seek end bit on positioning end; fault or 77 steps sets equipment bit
// RL14 - transfer to unready drive or missing side sets not-ready bit
// RL15 - result bits 2:0 hold side and unit at interrupt time
// RL16 - transfer status bit 7 past last sector; bits 6 and 3 read zero
// RL17 - transfer status bit 5 CRC fault, bit 4 host overrun
// RL18 - transfer status bit 2 when sector or ID cannot be found
// RL19 - transfer status bit 1 when write meets write-protect line
// RL20 - missing mark bit 0, also set with data-mark-missing field bit
// RL21 - field bit 7 zero, 6 deleted mark, 5 CRC, 4 cylinder, 1 bad track
// RL22 - field bit 3 scan equal hit, bit 2 scan unsatisfied
// RL23 - drive status mirrors five drive lines and three select outputs
module disk_ctrl_status_interrupt #(
	parameter int MS_CYCLES = disk_ctrl_pkg::MS_CYCLES_NOM
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic drive_fault_line_i,
	input wire logic write_protect_line_i,
	input wire logic drive_ready_line_i,
	input wire logic home_track_line_i,
	input wire logic double_sided_line_i,
	output logic step_o,
	output logic direction_o,
	output logic head_load_o,
	output logic side_select_o,
	output logic unit_select_hi_o,
	output logic unit_select_lo_o,
	output logic rw_go_o,
	output logic rw_is_write_o,
	output logic no_dma_select_o,
	input wire logic xfer_done_i,
	input wire logic [7:0] xfer_status_i,
	input wire logic [7:0] field_status_i,
	input wire logic byte_req_i,
	output logic int_o
);
	disk_ctrl_pkg::rw_state_type rw_state;
	disk_ctrl_pkg::seek_state_type sk_state;
	logic ack_r, cmd_go, cmd_ok, is_pos, is_rw, rw_ok, rw_launch, rw_end, ready_chg;
	logic sense_take, pos_go, ready_q, pend_v_r, owed_r, byte_int_r, seek_fin_r, step_r;
	logic dir_r, recal_r, head_load_r, unload_armed_r, rw_go_r, rw_write_r;
	logic [31:0] dat_r, rd_val;
	logic [7:0] cmd_byte, param0_r, param1_r, target_r, cyl_r, drive_bits;
	logic [7:0] sr0_r, sr1_r, sr2_r, sr3_r, pend_sr0_r, seek_sr0_r, x1, x2;
	logic [3:0] select_r, srt_r, hut_r;
	logic [6:0] hlt_r, steps_r;
	logic nd_r, req, wr_lo;
	timer_if step_t ();
	timer_if settle_t ();
	timer_if unload_t ();

	// commands the interpreter knows; everything else is invalid
	function automatic logic cmd_known(input logic [7:0] c);
		cmd_known = (c == disk_ctrl_pkg::CMD_SPECIFY) || (c == disk_ctrl_pkg::CMD_SENSE_DRIVE)
			|| (c == disk_ctrl_pkg::CMD_WRITE) || (c == disk_ctrl_pkg::CMD_READ)
			|| (c == disk_ctrl_pkg::CMD_RECAL) || (c == disk_ctrl_pkg::CMD_SENSE_INT)
			|| (c == disk_ctrl_pkg::CMD_SEEK);
	endfunction : cmd_known

	// result byte: termination, seek end, equipment, unready, side, unit
	function automatic logic [7:0] make_sr0(input logic [1:0] tc, input logic se,
			input logic eq, input logic nr, input logic [2:0] hu);
		make_sr0 = {tc, se, eq, nr, hu}; // RL12 RL15
	endfunction : make_sr0

	// wishbone slave: one wait cycle, ack for every address
	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_lo = req && wb_we_i && wb_sel_i[0];
	assign cmd_byte = wb_dat_i[7:0];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= req;
			if (req) begin
				dat_r <= rd_val;
			end
		end
	end

	// read decode; unmapped offsets read zero
	always_comb begin
		rd_val = '0;
		case (wb_adr_i)
			disk_ctrl_pkg::OFF_PARAM0: rd_val[7:0] = param0_r;
			disk_ctrl_pkg::OFF_PARAM1: rd_val[7:0] = param1_r;
			disk_ctrl_pkg::OFF_SELECT: rd_val[3:0] = select_r;
			disk_ctrl_pkg::OFF_TARGET: rd_val[7:0] = target_r;
			disk_ctrl_pkg::OFF_RESULT: rd_val[7:0] = sr0_r;
			disk_ctrl_pkg::OFF_XFER: rd_val[7:0] = sr1_r;
			disk_ctrl_pkg::OFF_FIELD: rd_val[7:0] = sr2_r;
			disk_ctrl_pkg::OFF_DRIVE: rd_val[7:0] = sr3_r;
			disk_ctrl_pkg::OFF_STATE: begin
				rd_val[15:0] = {cyl_r, 2'b00, nd_r, owed_r, head_load_r,
					sk_state != disk_ctrl_pkg::SK_IDLE, rw_state != disk_ctrl_pkg::RW_IDLE, int_o};
			end
			default: ;
		endcase
	end

	// parameter bytes and drive selection written by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			param0_r <= '0;
			param1_r <= '0;
			select_r <= '0;
			target_r <= '0;
		end else if (wr_lo) begin
			case (wb_adr_i)
				disk_ctrl_pkg::OFF_PARAM0: param0_r <= wb_dat_i[7:0];
				disk_ctrl_pkg::OFF_PARAM1: param1_r <= wb_dat_i[7:0];
				disk_ctrl_pkg::OFF_SELECT: select_r <= wb_dat_i[3:0];
				disk_ctrl_pkg::OFF_TARGET: target_r <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	assign side_select_o = select_r[disk_ctrl_pkg::SEL_SIDE];
	assign unit_select_hi_o = select_r[1];
	assign unit_select_lo_o = select_r[0];
	assign no_dma_select_o = nd_r;
	assign drive_bits = {drive_fault_line_i, write_protect_line_i, drive_ready_line_i,
		home_track_line_i, double_sided_line_i, select_r[2:0]}; // RL23

	// command acceptance; a transfer in progress blocks new commands
	assign cmd_go = wr_lo && (wb_adr_i == disk_ctrl_pkg::OFF_COMMAND)
		&& (rw_state == disk_ctrl_pkg::RW_IDLE);
	always_comb begin
		is_pos = (cmd_byte == disk_ctrl_pkg::CMD_SEEK) || (cmd_byte == disk_ctrl_pkg::CMD_RECAL);
		is_rw = (cmd_byte == disk_ctrl_pkg::CMD_READ) || (cmd_byte == disk_ctrl_pkg::CMD_WRITE);
		cmd_ok = cmd_known(cmd_byte) // RL10
			&& !(owed_r && (cmd_byte != disk_ctrl_pkg::CMD_SENSE_INT)) // RL11
			&& !(is_pos && (sk_state != disk_ctrl_pkg::SK_IDLE));
		rw_ok = drive_ready_line_i && !(select_r[disk_ctrl_pkg::SEL_SIDE] && !double_sided_line_i)
			&& !((cmd_byte == disk_ctrl_pkg::CMD_WRITE) && write_protect_line_i);
	end
	assign rw_launch = cmd_go && cmd_ok && is_rw && rw_ok;
	assign sense_take = cmd_go && cmd_ok && (cmd_byte == disk_ctrl_pkg::CMD_SENSE_INT);
	assign pos_go = cmd_go && cmd_ok && is_pos;
	assign ready_chg = ready_q != drive_ready_line_i;
	assign rw_end = ((rw_state == disk_ctrl_pkg::RW_EXEC) && (xfer_done_i || ready_chg))
		|| ((rw_state == disk_ctrl_pkg::RW_SETTLE) && ready_chg);

	// specify copies the parameter bytes into the timer codes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			srt_r <= '0;
			hut_r <= '0;
			hlt_r <= '0;
			nd_r <= 1'b0;
		end else if (cmd_go && cmd_ok && (cmd_byte == disk_ctrl_pkg::CMD_SPECIFY)) begin
			srt_r <= param0_r[7:4];
			hut_r <= param0_r[3:0];
			hlt_r <= param1_r[7:1];
			nd_r <= param1_r[0]; // RL9
		end
	end

	// engine status cleaned up: unused bits forced low, paired bits kept together
	always_comb begin
		x1 = xfer_status_i & disk_ctrl_pkg::XFER_USED_MASK; // RL16 RL17 RL18
		x2 = field_status_i & disk_ctrl_pkg::FIELD_USED_MASK; // RL21 RL22
		if (x2[disk_ctrl_pkg::BIT_DATA_MARK_MISSING]) begin
			x1[disk_ctrl_pkg::BIT_MARK_MISSING] = 1'b1; // RL20
		end
		if (x2[disk_ctrl_pkg::BIT_BAD_TRACK]) begin
			x2[disk_ctrl_pkg::BIT_CYL_MISMATCH] = 1'b1; // RL21
		end
	end

	// command results and transfer sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rw_state <= disk_ctrl_pkg::RW_IDLE;
			sr0_r <= disk_ctrl_pkg::STATUS_RESET;
			sr1_r <= disk_ctrl_pkg::STATUS_RESET;
			sr2_r <= disk_ctrl_pkg::STATUS_RESET;
			sr3_r <= disk_ctrl_pkg::STATUS_RESET;
			rw_go_r <= 1'b0;
			rw_write_r <= 1'b0;
		end else begin
			rw_go_r <= 1'b0;
			case (rw_state)
				disk_ctrl_pkg::RW_IDLE: begin
					if (cmd_go && !cmd_ok) begin
						sr0_r <= make_sr0(disk_ctrl_pkg::TERM_INVALID, 1'b0, 1'b0, 1'b0,
							select_r[2:0]); // RL10 RL11
					end else if (cmd_go && (cmd_byte == disk_ctrl_pkg::CMD_SENSE_INT)) begin
						sr0_r <= pend_v_r ? pend_sr0_r : make_sr0(disk_ctrl_pkg::TERM_INVALID,
							1'b0, 1'b0, 1'b0, select_r[2:0]); // RL2
					end else if (cmd_go && (cmd_byte == disk_ctrl_pkg::CMD_SENSE_DRIVE)) begin
						sr3_r <= drive_bits; // RL23
					end else if (cmd_go && is_rw) begin
						rw_write_r <= cmd_byte == disk_ctrl_pkg::CMD_WRITE;
						sr1_r <= disk_ctrl_pkg::STATUS_RESET;
						sr2_r <= disk_ctrl_pkg::STATUS_RESET;
						if (!rw_ok) begin
							// refused before start: not-ready or write-protected
							// not-ready only for a dead drive or side 1 of a one-sided drive
							sr0_r <= make_sr0(disk_ctrl_pkg::TERM_ABNORMAL, 1'b0, 1'b0,
								!drive_ready_line_i || (select_r[disk_ctrl_pkg::SEL_SIDE]
								&& !double_sided_line_i), select_r[2:0]); // RL14
							sr1_r[disk_ctrl_pkg::BIT_WRITE_BLOCKED] <= drive_ready_line_i
								&& (cmd_byte == disk_ctrl_pkg::CMD_WRITE)
								&& write_protect_line_i; // RL19
						end else if (head_load_r) begin
							rw_go_r <= 1'b1;
							rw_state <= disk_ctrl_pkg::RW_EXEC;
						end else begin
							rw_state <= disk_ctrl_pkg::RW_SETTLE;
						end
					end
				end
				disk_ctrl_pkg::RW_SETTLE: begin
					if (ready_chg) begin
						sr0_r <= make_sr0(disk_ctrl_pkg::TERM_READY, 1'b0, 1'b0, 1'b1,
							select_r[2:0]); // RL12
						rw_state <= disk_ctrl_pkg::RW_IDLE;
					end else if (settle_t.done) begin
						rw_go_r <= 1'b1; // RL7
						rw_state <= disk_ctrl_pkg::RW_EXEC;
					end
				end
				disk_ctrl_pkg::RW_EXEC: begin
					if (ready_chg) begin
						sr0_r <= make_sr0(disk_ctrl_pkg::TERM_READY, 1'b0, 1'b0, 1'b1,
							select_r[2:0]); // RL12
						rw_state <= disk_ctrl_pkg::RW_IDLE;
					end else if (xfer_done_i) begin
						sr1_r <= x1;
						sr2_r <= x2;
						sr0_r <= make_sr0(((x1 != 8'h00) || ((x2 & disk_ctrl_pkg::FIELD_ERROR_MASK)
							!= 8'h00) || drive_fault_line_i) ? disk_ctrl_pkg::TERM_ABNORMAL
							: disk_ctrl_pkg::TERM_NORMAL, 1'b0, drive_fault_line_i, 1'b0,
							select_r[2:0]); // RL12 RL13
						rw_state <= disk_ctrl_pkg::RW_IDLE;
					end
				end
				default: rw_state <= disk_ctrl_pkg::RW_IDLE;
			endcase
		end
	end
	assign rw_go_o = rw_go_r;
	assign rw_is_write_o = rw_write_r;

	// head load and unload; a new transfer cancels a pending unload
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			head_load_r <= 1'b0;
			unload_armed_r <= 1'b0;
		end else if (rw_launch) begin
			head_load_r <= 1'b1;
			unload_armed_r <= 1'b0;
		end else if (rw_end) begin
			unload_armed_r <= 1'b1; // RL5
		end else if (unload_armed_r && unload_t.done) begin
			head_load_r <= 1'b0; // RL5
			unload_armed_r <= 1'b0;
		end
	end
	assign head_load_o = head_load_r;

	assign settle_t.start = rw_launch && !head_load_r;
	assign settle_t.ms_count = 9'({hlt_r, 1'b0}) + disk_ctrl_pkg::SETTLE_UNIT_MS; // RL7
	assign unload_t.start = rw_end;
	assign unload_t.ms_count = {1'b0, hut_r, 4'h0}; // RL5
	assign step_t.start = step_r;
	assign step_t.ms_count = {4'h0, disk_ctrl_pkg::STEP_SPAN_MS - {1'b0, srt_r}}; // RL6

	interval_timer #(.MS_CYCLES(MS_CYCLES)) u_settle (.clk_i(clk_i), .rst_i(rst_i),
		.half_rate_i(select_r[disk_ctrl_pkg::SEL_HALF_RATE]), .tmr(settle_t));
	interval_timer #(.MS_CYCLES(MS_CYCLES)) u_unload (.clk_i(clk_i), .rst_i(rst_i),
		.half_rate_i(select_r[disk_ctrl_pkg::SEL_HALF_RATE]), .tmr(unload_t));
	interval_timer #(.MS_CYCLES(MS_CYCLES)) u_step (.clk_i(clk_i), .rst_i(rst_i),
		.half_rate_i(select_r[disk_ctrl_pkg::SEL_HALF_RATE]), .tmr(step_t));

	// seek and recalibrate stepping; runs beside other commands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sk_state <= disk_ctrl_pkg::SK_IDLE;
			cyl_r <= '0;
			steps_r <= '0;
			recal_r <= 1'b0;
			dir_r <= 1'b0;
			step_r <= 1'b0;
			seek_fin_r <= 1'b0;
			seek_sr0_r <= disk_ctrl_pkg::STATUS_RESET;
		end else begin
			step_r <= 1'b0;
			seek_fin_r <= 1'b0;
			case (sk_state)
				disk_ctrl_pkg::SK_IDLE: begin
					if (pos_go) begin
						recal_r <= cmd_byte == disk_ctrl_pkg::CMD_RECAL;
						steps_r <= '0;
						if (cmd_byte == disk_ctrl_pkg::CMD_RECAL) begin
							cyl_r <= '0;
						end
						sk_state <= disk_ctrl_pkg::SK_CHECK;
					end
				end
				disk_ctrl_pkg::SK_CHECK: begin
					sk_state <= disk_ctrl_pkg::SK_IDLE;
					seek_fin_r <= 1'b1;
					if (!drive_ready_line_i) begin
						seek_sr0_r <= make_sr0(disk_ctrl_pkg::TERM_ABNORMAL, 1'b1, 1'b0, 1'b1,
							select_r[2:0]);
					end else if (drive_fault_line_i) begin
						seek_sr0_r <= make_sr0(disk_ctrl_pkg::TERM_ABNORMAL, 1'b1, 1'b1, 1'b0,
							select_r[2:0]); // RL13
					end else if (recal_r ? home_track_line_i : (cyl_r == target_r)) begin
						seek_sr0_r <= make_sr0(disk_ctrl_pkg::TERM_NORMAL, 1'b1, 1'b0, 1'b0,
							select_r[2:0]); // RL13 RL3
					end else if (recal_r && (steps_r == disk_ctrl_pkg::RECAL_STEP_LIMIT)) begin
						seek_sr0_r <= make_sr0(disk_ctrl_pkg::TERM_ABNORMAL, 1'b1, 1'b1, 1'b0,
							select_r[2:0]); // RL13
					end else begin
						// another step, then wait out the step interval
						seek_fin_r <= 1'b0;
						step_r <= 1'b1;
						dir_r <= recal_r || (cyl_r < target_r);
						if (!recal_r) begin
							cyl_r <= (cyl_r < target_r) ? cyl_r + 8'h01 : cyl_r - 8'h01;
						end
						steps_r <= steps_r + 7'h01;
						sk_state <= disk_ctrl_pkg::SK_WAIT;
					end
				end
				disk_ctrl_pkg::SK_WAIT: begin
					if (step_t.done) begin
						sk_state <= disk_ctrl_pkg::SK_CHECK; // RL6
					end
				end
				default: sk_state <= disk_ctrl_pkg::SK_IDLE;
			endcase
		end
	end
	assign step_o = step_r;
	assign direction_o = dir_r;

	// pending cause; a new event beats a sense in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_q <= drive_ready_line_i;
			pend_v_r <= 1'b0;
			pend_sr0_r <= disk_ctrl_pkg::STATUS_RESET;
			owed_r <= 1'b0;
			byte_int_r <= 1'b0;
		end else begin
			ready_q <= drive_ready_line_i;
			byte_int_r <= byte_req_i && nd_r && (rw_state == disk_ctrl_pkg::RW_EXEC); // RL1 RL9
			if (seek_fin_r) begin
				pend_v_r <= 1'b1; // RL1
				pend_sr0_r <= seek_sr0_r;
			end else if (ready_chg) begin
				pend_v_r <= 1'b1; // RL1
				pend_sr0_r <= make_sr0(disk_ctrl_pkg::TERM_READY, 1'b0, 1'b0,
					!drive_ready_line_i, select_r[2:0]); // RL3
			end else if (sense_take) begin
				pend_v_r <= 1'b0; // RL2
			end
			if (seek_fin_r) begin
				owed_r <= 1'b1; // RL4 RL11
			end else if (sense_take) begin
				owed_r <= 1'b0;
			end
		end
	end
	assign int_o = pend_v_r || byte_int_r;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_seek_int; seek_fin_r |=> int_o; endproperty
	a_seek_int: assert property (p_seek_int) else $error("no interrupt after seek end"); // RL1
	property p_ready_code; ready_chg && !seek_fin_r |=> pend_sr0_r[7:5] == 3'h6; endproperty
	a_ready_code: assert property (p_ready_code) else $error("bad ready change code"); // RL3
	property p_sense_clr; sense_take && !seek_fin_r && !ready_chg && !byte_int_r
		&& !(byte_req_i && nd_r) |=> !int_o; endproperty
	a_sense_clr: assert property (p_sense_clr) else $error("sense left interrupt"); // RL2
	property p_sense_rep; sense_take && pend_v_r |=> sr0_r == $past(pend_sr0_r); endproperty
	a_sense_rep: assert property (p_sense_rep) else $error("sense cause not reported"); // RL2
	property p_invalid; cmd_go && !cmd_known(cmd_byte) |=> sr0_r[7:6] == 2'h2; endproperty
	a_invalid: assert property (p_invalid) else $error("undefined command not invalid"); // RL10
	property p_owed; cmd_go && owed_r && (cmd_byte != disk_ctrl_pkg::CMD_SENSE_INT)
		|=> sr0_r[7:6] == 2'h2 && rw_state == disk_ctrl_pkg::RW_IDLE; endproperty
	a_owed: assert property (p_owed) else $error("command after seek end accepted"); // RL11
	property p_step_gap; step_r |=> !step_r [*2]; endproperty
	a_step_gap: assert property (p_step_gap) else $error("step pulses too close"); // RL6
	property p_recal_max; steps_r <= disk_ctrl_pkg::RECAL_STEP_LIMIT; endproperty
	a_recal_max: assert property (p_recal_max) else $error("more than 77 steps"); // RL13
	property p_unready; cmd_go && cmd_ok && is_rw && !drive_ready_line_i
		|=> sr0_r[7:6] == 2'h1 && sr0_r[3]; endproperty
	a_unready: assert property (p_unready) else $error("unready transfer not refused"); // RL14
	property p_zero_bits; !sr1_r[6] && !sr1_r[3] && !sr2_r[7]; endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("unused status bit set"); // RL16
	property p_drive; cmd_go && cmd_ok && (cmd_byte == disk_ctrl_pkg::CMD_SENSE_DRIVE)
		|=> sr3_r == $past(drive_bits); endproperty
	a_drive: assert property (p_drive) else $error("drive status mismatch"); // RL23
	property p_settle; settle_t.start |=> head_load_o && !rw_go_o [*2]; endproperty
	a_settle: assert property (p_settle) else $error("transfer began before settle"); // RL7
	c_seek: cover property (seek_fin_r && !seek_sr0_r[6]);
	c_sense: cover property (sense_take && pend_v_r);
	c_invalid: cover property (cmd_go && !cmd_ok);
	c_xfer: cover property (rw_go_r ##[1:20] xfer_done_i);
endmodule : disk_ctrl_status_interrupt

//--- tb/drive_model.sv
`timescale 1ns/1ps
// far-side drive: home track shows only after three steps, never when stuck
module drive_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic step_i,
	input wire logic reachable_i,
	input wire logic ready_i,
	output logic drive_ready_line_o,
	output logic home_track_line_o
);
	logic [7:0] steps_r;
	// head travel counted in step pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) steps_r <= 8'h00;
		else if (step_i) steps_r <= steps_r + 8'h01;
	end
	assign home_track_line_o = reachable_i && (steps_r >= 8'h03);
	assign drive_ready_line_o = ready_i;
endmodule : drive_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic we = 1'b0, cyc = 1'b0, stb = 1'b0, done = 1'b0, breq = 1'b0;
	logic rdy = 1'b1, reach = 1'b1, wp = 1'b0;
	logic [7:0] xst = 8'h00, fst = 8'h00, q;
	logic [31:0] rdat;
	logic ack, step, rw_go, nd, intr, ready_ln, home_ln, hl;
	int miscompares = 0, n_compared = 0, cyc_cnt = 0;
	// short millisecond keeps the recalibrate run small
	disk_ctrl_status_interrupt #(.MS_CYCLES(4)) disk_ctrl_status_interrupt_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_we_i(we), .wb_sel_i(4'h1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
		.drive_fault_line_i(1'b0), .write_protect_line_i(wp), .drive_ready_line_i(ready_ln),
		.home_track_line_i(home_ln), .double_sided_line_i(1'b0), .step_o(step),
		.direction_o(), .head_load_o(hl), .side_select_o(), .unit_select_hi_o(),
		.unit_select_lo_o(), .rw_go_o(rw_go), .rw_is_write_o(), .no_dma_select_o(nd),
		.xfer_done_i(done), .xfer_status_i(xst), .field_status_i(fst), .byte_req_i(breq),
		.int_o(intr));
	drive_model drive_model_inst (.clk_i(clk_i), .rst_i(rst_i), .step_i(step),
		.reachable_i(reach), .ready_i(rdy), .drive_ready_line_o(ready_ln),
		.home_track_line_o(home_ln));
	initial forever #10 clk_i = ~clk_i;
	// a hang ends the run as a failure
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 6000) begin
			miscompares++;
			wrap_up();
		end
	end
	task wrap_up;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// classic cycle, held until ack is sampled
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(q, exp);
	endtask : rdc
	// bounded wait on interrupt (0) or transfer start (1)
	task wait_sig(input int which);
		int n;
		n = 0;
		while (((which == 1) ? rw_go : intr) !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		chk({7'h0, n < 2000}, 8'h01);
	endtask : wait_sig
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(disk_ctrl_pkg::OFF_RESULT, disk_ctrl_pkg::STATUS_RESET);
		wr(disk_ctrl_pkg::OFF_SELECT, 8'h01);
		wr(disk_ctrl_pkg::OFF_PARAM0, 8'hf0); // step code f: 1 ms
		wr(disk_ctrl_pkg::OFF_PARAM1, 8'h01);
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_SPECIFY);
		chk({7'h0, nd}, 8'h01);
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_SENSE_DRIVE);
		rdc(disk_ctrl_pkg::OFF_DRIVE, 8'h21);
		$display("setup test done");
		wr(disk_ctrl_pkg::OFF_TARGET, 8'h02);
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_SEEK);
		wait_sig(0);
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_READ);
		rdc(disk_ctrl_pkg::OFF_RESULT, 8'h81);
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_SENSE_INT);
		rdc(disk_ctrl_pkg::OFF_RESULT, 8'h21);
		chk({7'h0, intr}, 8'h00);
		wr(disk_ctrl_pkg::OFF_COMMAND, 8'h1e);
		rdc(disk_ctrl_pkg::OFF_RESULT, 8'h81);
		$display("seek test done");
		reach <= 1'b0;
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_RECAL);
		wait_sig(0);
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_SENSE_INT);
		rdc(disk_ctrl_pkg::OFF_RESULT, 8'h71);
		$display("recalibrate test done");
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_READ);
		wait_sig(1);
		chk({7'h0, hl}, 8'h01);
		breq <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({7'h0, intr}, 8'h01);
		breq <= 1'b0;
		xst <= 8'h48;
		fst <= 8'h81;
		done <= 1'b1;
		@(posedge clk_i);
		done <= 1'b0;
		rdc(disk_ctrl_pkg::OFF_XFER, 8'h01);
		rdc(disk_ctrl_pkg::OFF_FIELD, 8'h01);
		rdc(disk_ctrl_pkg::OFF_RESULT, 8'h41);
		$display("transfer test done");
		// refused transfers: protected write, then side 1 of a one-sided drive
		wp <= 1'b1;
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_WRITE);
		rdc(disk_ctrl_pkg::OFF_XFER, 8'h02);
		rdc(disk_ctrl_pkg::OFF_RESULT, 8'h41);
		wp <= 1'b0;
		wr(disk_ctrl_pkg::OFF_SELECT, 8'h05);
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_READ);
		rdc(disk_ctrl_pkg::OFF_RESULT, 8'h4d);
		wr(disk_ctrl_pkg::OFF_SELECT, 8'h01);
		$display("refusal test done");
		rdy <= 1'b0;
		wait_sig(0);
		wr(disk_ctrl_pkg::OFF_COMMAND, disk_ctrl_pkg::CMD_SENSE_INT);
		rdc(disk_ctrl_pkg::OFF_RESULT, 8'hc9);
		$display("ready change test done");
		wrap_up();
	end
endmodule : tb
